// ==== design/qec_defs.svh ====
`ifndef QEC_DEFS_SVH
`define QEC_DEFS_SVH
// Summary of operation
// - Count up or down following the order of A and B transitions.
// - Direction bit picks which rising-edge order counts as positive.
// - At maximum, a positive edge wraps the count to zero.
// - At zero, a negative edge loads the configured maximum.
// - Enabled index reset clears the count on an index rising edge.
// - Outputs: present count, angular velocity, status word.
// - Status holds direction and index-seen-last-step flag.
// - Counting mode picks counted edges: x1, x2 or x4 per line pair.
// - Reset method picks index reset or overflow-only wrap.
// - Reset condition gives required A, B, I levels for index reset.
// - Input type picks single-ended or differential true/complement reception.
// - Two independent counters; configuration picks which encoder each serves.
// - With index disabled, index input is ignored and never resets.

// Register byte offsets, instance k at base + 4*k; the step length register is single and shared
`define QEC_REG_CFG 8'h00
`define QEC_REG_MAX 8'h08
`define QEC_REG_VSCALE 8'h10
`define QEC_REG_COUNT 8'h18
`define QEC_REG_VEL 8'h20
`define QEC_REG_STAT 8'h28
`define QEC_REG_STEP 8'h30

// Configuration fields
`define QEC_CFG_MODE_LSB 0
`define QEC_CFG_DIRPOL 2
`define QEC_CFG_DIFF 3
`define QEC_CFG_IDXEN 4
`define QEC_CFG_RSTIDX 5
`define QEC_CFG_COND_LSB 6
`define QEC_CFG_SRC 9

// Reset values
`define QEC_CFG_RST 32'h0000_0002
`define QEC_MAX_RST 32'h0000_0fff
`define QEC_VSCALE_RST 32'h0000_0000

// Model step timing
`define QEC_CLK_NS 10
`define QEC_STEP_NS 100000
`define QEC_STEP_CYC (`QEC_STEP_NS / `QEC_CLK_NS)
`endif

// ==== design/qec_pkg.sv ====
package qec_pkg;
  typedef enum logic [1:0] {qec_cnt_x1, qec_cnt_x2, qec_cnt_x4} qec_mode_t;
  typedef enum logic {qec_rst_overflow, qec_rst_index} qec_rst_t;
endpackage

// ==== design/qec_input_rx.sv ====
`timescale 1ns/1ps
module qec_input_rx (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Pins and mode
  input wire logic p_in,
  input wire logic n_in,
  input wire logic diff_in,
  // Received level
  output logic lvl_out
);
  logic [1:0] p_sync_q;
  logic [1:0] n_sync_q;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      p_sync_q <= 2'h0;
      n_sync_q <= 2'h0;
    end
    else
    begin
      p_sync_q <= {p_sync_q[0], p_in};
      n_sync_q <= {n_sync_q[0], n_in};
    end
  end

  // Equal true and complement is not a valid level, so keep the last one
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      lvl_out <= 1'b0;
    else if (!diff_in || (p_sync_q[1] != n_sync_q[1]))
      lvl_out <= p_sync_q[1];
  end

  AST_RX_DIFF_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    diff_in && (p_sync_q[1] == n_sync_q[1]) |=> $stable(lvl_out))
    else $error("Differential level changed on invalid pair");
endmodule

// ==== design/qec_counter_core.sv ====
`timescale 1ns/1ps
module qec_counter_core #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Received levels
  input wire logic a_in,
  input wire logic b_in,
  input wire logic i_in,
  // Configuration
  input wire qec_pkg::qec_mode_t mode_in,
  input wire logic dir_pol_in,
  input wire logic idx_en_in,
  input wire qec_pkg::qec_rst_t rst_meth_in,
  input wire logic [2:0] rst_cond_in,
  input wire logic [CNT_W-1:0] max_in,
  // Results
  output logic [CNT_W-1:0] count_out,
  output logic dir_out,
  output logic up_out,
  output logic dn_out,
  output logic idx_out
);
  logic a_q;
  logic b_q;
  logic i_q;
  logic valid_q;
  logic a_chg;
  logic b_chg;
  logic single;
  logic fwd;
  logic counted;
  logic cnt_ev;
  logic idx_edge;
  logic idx_clr;

  function automatic logic [CNT_W-1:0] next_count(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] m,
    input logic up);
    if (up)
      next_count = (c >= m) ? '0 : c + 1'b1;
    else
      next_count = (c == '0) ? m : c - 1'b1;
  endfunction

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      i_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      a_q <= a_in;
      b_q <= b_in;
      i_q <= i_in;
      valid_q <= 1'b1;
    end
  end

  always_comb
  begin
    a_chg = a_in ^ a_q;
    b_chg = b_in ^ b_q;
    single = valid_q & (a_chg ^ b_chg);
    fwd = a_in ^ b_q ^ dir_pol_in;
    unique case (mode_in)
      qec_pkg::qec_cnt_x1: counted = a_chg & a_in;
      qec_pkg::qec_cnt_x2: counted = a_chg;
      qec_pkg::qec_cnt_x4: counted = 1'b1;
      default: counted = 1'b0;
    endcase
    cnt_ev = single & counted;
    idx_edge = idx_en_in & valid_q & i_in & ~i_q;
    idx_clr = idx_edge & (rst_meth_in == qec_pkg::qec_rst_index) & ({a_in, b_in, i_in} == rst_cond_in);
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      count_out <= '0;
    else if (idx_clr)
      count_out <= '0;
    else if (cnt_ev)
      count_out <= next_count(count_out, max_in, fwd);
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      dir_out <= 1'b0;
      up_out <= 1'b0;
      dn_out <= 1'b0;
      idx_out <= 1'b0;
    end
    else
    begin
      if (cnt_ev)
        dir_out <= fwd;
      up_out <= cnt_ev & fwd;
      dn_out <= cnt_ev & ~fwd;
      idx_out <= idx_edge;
    end
  end

  AST_CNT_INC: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    cnt_ev && fwd && !idx_clr && (count_out < max_in) |=> count_out == $past(count_out) + 1'b1)
    else $error("Positive edge did not increment");
  AST_CNT_WRAP_UP: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    cnt_ev && fwd && !idx_clr && (count_out >= max_in) |=> count_out == '0)
    else $error("Count did not wrap to zero");
  AST_CNT_WRAP_DN: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    cnt_ev && !fwd && !idx_clr && (count_out == '0) |=> count_out == $past(max_in))
    else $error("Count did not load maximum");
  AST_IDX_CLR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    idx_clr |=> count_out == '0)
    else $error("Index reset did not clear count");
  AST_BOTH_IGNORED: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    valid_q && a_chg && b_chg && !idx_clr |=> $stable(count_out) && !up_out && !dn_out)
    else $error("Simultaneous change was counted");
  AST_DIR_POL: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    cnt_ev |=> dir_out == ($past(a_in) ^ $past(b_q) ^ $past(dir_pol_in)))
    else $error("Direction does not follow polarity");
  AST_X1_MODE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (mode_in == qec_pkg::qec_cnt_x1) && !(a_chg && a_in) |=> !up_out && !dn_out)
    else $error("Single mode counted a non A rising edge");
  AST_IDX_DIS: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !idx_en_in && !idx_clr && !cnt_ev |=> $stable(count_out) && !idx_out)
    else $error("Disabled index acted");
endmodule

// ==== design/qec_top.sv ====
`timescale 1ns/1ps
`include "qec_defs.svh"
module qec_top #(
  parameter int CNT_W = 32,
  parameter int STEP_CYC = `QEC_STEP_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Encoder pins, one bit per encoder
  input wire logic [1:0] enc_a_in,
  input wire logic [1:0] enc_a_n_in,
  input wire logic [1:0] enc_b_in,
  input wire logic [1:0] enc_b_n_in,
  input wire logic [1:0] enc_i_in,
  input wire logic [1:0] enc_i_n_in,
  // Per-step results, one entry per counter, and one shared step pulse
  output logic [1:0][CNT_W-1:0] count_out,
  output logic [1:0][31:0] velocity_out,
  output logic [1:0][1:0] status_out,
  output logic step_out
);
  localparam int NCH = 2;

  logic [31:0] cfg_q [NCH];
  logic [CNT_W-1:0] max_q [NCH];
  logic [31:0] vscale_q [NCH];
  logic [31:0] step_len_q;
  logic [31:0] step_cnt_q;
  logic step_pls;
  logic signed [15:0] delta_q [NCH];
  logic idx_acc_q [NCH];

  logic [CNT_W-1:0] live_cnt [NCH];
  logic live_dir [NCH];
  logic live_up [NCH];
  logic live_dn [NCH];
  logic live_idx [NCH];
  logic signed [15:0] delta_d [NCH];

  function automatic logic [7:0] addr_of(input logic [7:0] base, input int k);
    addr_of = base + 8'(k * 4);
  endfunction

  // Register writes
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      for (int k = 0; k < NCH; k++)
      begin
        cfg_q[k] <= `QEC_CFG_RST;
        max_q[k] <= CNT_W'(`QEC_MAX_RST);
        vscale_q[k] <= `QEC_VSCALE_RST;
      end
    end
    else if (reg_wr_in)
    begin
      for (int k = 0; k < NCH; k++)
      begin
        if (reg_addr_in == addr_of(`QEC_REG_CFG, k))
          cfg_q[k] <= reg_wdata_in;
        if (reg_addr_in == addr_of(`QEC_REG_MAX, k))
          max_q[k] <= CNT_W'(reg_wdata_in);
        if (reg_addr_in == addr_of(`QEC_REG_VSCALE, k))
          vscale_q[k] <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      step_len_q <= 32'(STEP_CYC);
    else if (reg_wr_in && (reg_addr_in == `QEC_REG_STEP))
      step_len_q <= reg_wdata_in;
  end

  // Register reads, unmapped offsets return zero
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
      if (reg_addr_in == `QEC_REG_STEP)
        reg_rdata_out <= step_len_q;
      for (int k = 0; k < NCH; k++)
      begin
        if (reg_addr_in == addr_of(`QEC_REG_CFG, k))
          reg_rdata_out <= cfg_q[k];
        if (reg_addr_in == addr_of(`QEC_REG_MAX, k))
          reg_rdata_out <= 32'(max_q[k]);
        if (reg_addr_in == addr_of(`QEC_REG_VSCALE, k))
          reg_rdata_out <= vscale_q[k];
        if (reg_addr_in == addr_of(`QEC_REG_COUNT, k))
          reg_rdata_out <= 32'(live_cnt[k]);
        if (reg_addr_in == addr_of(`QEC_REG_VEL, k))
          reg_rdata_out <= velocity_out[k];
        if (reg_addr_in == addr_of(`QEC_REG_STAT, k))
          reg_rdata_out <= {30'h0000_0000, status_out[k]};
      end
    end
  end

  // Model step timer; a length of zero or one gives a step every cycle
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      step_cnt_q <= 32'h0000_0000;
    else if (step_pls)
      step_cnt_q <= 32'h0000_0000;
    else
      step_cnt_q <= step_cnt_q + 32'h0000_0001;
  end

  assign step_pls = (step_cnt_q + 32'h0000_0001) >= step_len_q;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      step_out <= 1'b0;
    else
      step_out <= step_pls;
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    logic src;
    logic diff;
    logic a_lvl;
    logic b_lvl;
    logic i_lvl;

    assign src = cfg_q[g][`QEC_CFG_SRC];
    assign diff = cfg_q[g][`QEC_CFG_DIFF];

    qec_input_rx u_rx_a (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .p_in(enc_a_in[src]),
      .n_in(enc_a_n_in[src]),
      .diff_in(diff),
      .lvl_out(a_lvl)
    );

    qec_input_rx u_rx_b (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .p_in(enc_b_in[src]),
      .n_in(enc_b_n_in[src]),
      .diff_in(diff),
      .lvl_out(b_lvl)
    );

    qec_input_rx u_rx_i (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .p_in(enc_i_in[src]),
      .n_in(enc_i_n_in[src]),
      .diff_in(diff),
      .lvl_out(i_lvl)
    );

    qec_counter_core #(
      .CNT_W(CNT_W)
    ) u_core (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .a_in(a_lvl),
      .b_in(b_lvl),
      .i_in(i_lvl),
      .mode_in(qec_pkg::qec_mode_t'(cfg_q[g][`QEC_CFG_MODE_LSB +: 2])),
      .dir_pol_in(cfg_q[g][`QEC_CFG_DIRPOL]),
      .idx_en_in(cfg_q[g][`QEC_CFG_IDXEN]),
      .rst_meth_in(qec_pkg::qec_rst_t'(cfg_q[g][`QEC_CFG_RSTIDX])),
      .rst_cond_in(cfg_q[g][`QEC_CFG_COND_LSB +: 3]),
      .max_in(max_q[g]),
      .count_out(live_cnt[g]),
      .dir_out(live_dir[g]),
      .up_out(live_up[g]),
      .dn_out(live_dn[g]),
      .idx_out(live_idx[g])
    );
  end

  // Net edges within the running step; wraps are invisible here
  always_comb
  begin
    for (int k = 0; k < NCH; k++)
      delta_d[k] = delta_q[k] + 16'(live_up[k]) - 16'(live_dn[k]);
  end

  // An edge or index in the boundary cycle belongs to the ending step
  always_ff @(posedge mclk_in)
  begin
    for (int k = 0; k < NCH; k++)
    begin
      if (sys_rst_in)
      begin
        delta_q[k] <= 16'sh0000;
        idx_acc_q[k] <= 1'b0;
      end
      else if (step_pls)
      begin
        delta_q[k] <= 16'sh0000;
        idx_acc_q[k] <= 1'b0;
      end
      else
      begin
        delta_q[k] <= delta_d[k];
        idx_acc_q[k] <= idx_acc_q[k] | live_idx[k];
      end
    end
  end

  // Velocity is net edges times a per-edge scale in Q16.16 rad/s
  always_ff @(posedge mclk_in)
  begin
    for (int k = 0; k < NCH; k++)
    begin
      if (sys_rst_in)
      begin
        count_out[k] <= '0;
        velocity_out[k] <= 32'h0000_0000;
        status_out[k] <= 2'h0;
      end
      else if (step_pls)
      begin
        count_out[k] <= live_cnt[k];
        velocity_out[k] <= 32'(32'(delta_d[k]) * $signed(vscale_q[k]));
        status_out[k] <= {idx_acc_q[k] | live_idx[k], live_dir[k]};
      end
    end
  end

  AST_RD_COUNT0: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `QEC_REG_COUNT) |=> reg_rdata_out == 32'($past(live_cnt[0])))
    else $error("Count read data wrong");
  AST_STEP_COUNT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls |=> step_out && (count_out[0] == $past(live_cnt[0])) && (count_out[1] == $past(live_cnt[1])))
    else $error("Count not refreshed at step");
  AST_STEP_IDX: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls && (idx_acc_q[0] || live_idx[0]) |=> status_out[0][1])
    else $error("Index in step not reported");
  AST_STEP_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !step_pls |=> $stable(status_out) && $stable(count_out) && !step_out)
    else $error("Outputs changed between steps");

  // Register port checks
  AST_RD_COUNT1: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `QEC_REG_COUNT + 8'h04) |=> reg_rdata_out == 32'($past(live_cnt[1])))
    else $error("Second count read data wrong");
  AST_RD_CFG0: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `QEC_REG_CFG) |=> reg_rdata_out == $past(cfg_q[0]))
    else $error("Configuration read data wrong");
  AST_RD_VEL0: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `QEC_REG_VEL) |=> reg_rdata_out == $past(velocity_out[0]))
    else $error("Velocity read data wrong");
  AST_RD_STAT0: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `QEC_REG_STAT) |=> reg_rdata_out == {30'h0000_0000, $past(status_out[0])})
    else $error("Status read data wrong");
  AST_RD_STEP: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `QEC_REG_STEP) |=> reg_rdata_out == $past(step_len_q))
    else $error("Step length read data wrong");
  AST_WR_MAX0: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    reg_wr_in && (reg_addr_in == `QEC_REG_MAX) |=> max_q[0] == CNT_W'($past(reg_wdata_in)))
    else $error("Maximum write did not land");

  // Step boundary: one-cycle pulse, fresh status, cleared accumulators
  AST_STEP_ONE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_out && (step_len_q > 32'h0000_0001) |=> !step_out)
    else $error("Step pulse longer than one cycle");
  AST_STEP_NOIDX: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls && !idx_acc_q[0] && !live_idx[0] |=> !status_out[0][1])
    else $error("Index flag set without index");
  AST_STEP_DIR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls |=> (status_out[0][0] == $past(live_dir[0])) && (status_out[1][0] == $past(live_dir[1])))
    else $error("Direction not latched at step");
  AST_IDX_ACC: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    live_idx[0] && !step_pls |=> idx_acc_q[0])
    else $error("Index inside step was lost");
  AST_DELTA_CLR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls |=> (delta_q[0] == 16'sh0000) && (delta_q[1] == 16'sh0000))
    else $error("Edge tally not cleared at step");

  // No motion or no scale must give zero velocity
  AST_VEL_ZERO: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls && (vscale_q[0] == 32'h0000_0000) |=> velocity_out[0] == 32'h0000_0000)
    else $error("Velocity nonzero with zero scale");
  AST_VEL_STILL: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls && (delta_d[0] == 16'sh0000) |=> velocity_out[0] == 32'h0000_0000)
    else $error("Velocity nonzero without motion");
  AST_VEL_STILL1: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    step_pls && (delta_d[1] == 16'sh0000) |=> velocity_out[1] == 32'h0000_0000)
    else $error("Second velocity nonzero without motion");
endmodule

// ==== dv/qec_enc_model.sv ====
`timescale 1ns/1ps
module qec_enc_model (
  // Clock
  input wire logic clk_in,
  // Motion commands, one-cycle pulses; the index input is a level held for several cycles
  input wire logic fwd_in,
  input wire logic rev_in,
  input wire logic both_in,
  input wire logic idx_in,
  // A and B complement lines follow the true lines, a deliberate pair fault; the index complement stays inverted
  input wire logic brk_in,
  // Encoder lines
  output logic a_out,
  output logic an_out,
  output logic b_out,
  output logic bn_out,
  output logic i_out,
  output logic in_out
);
  logic [1:0] ph_q = 2'h0;
  // Both-channel jump is a deliberate fault the counter must ignore
  always @(posedge clk_in)
  begin
    if (both_in)
      ph_q <= ph_q + 2'h2;
    else if (fwd_in)
      ph_q <= ph_q + 2'h1;
    else if (rev_in)
      ph_q <= ph_q - 2'h1;
  end
  // Forward walks AB 00,10,11,01
  assign a_out = ph_q[1] ^ ph_q[0];
  assign b_out = ph_q[1];
  assign an_out = brk_in ? a_out : ~a_out;
  assign bn_out = brk_in ? b_out : ~b_out;
  assign i_out = idx_in;
  assign in_out = ~idx_in;
endmodule

// ==== dv/tb_qec_top.sv ====
`timescale 1ns/1ps
module tb_qec_top;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdq;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] fw = 2'h0;
  logic [1:0] rv = 2'h0;
  logic [1:0] bo = 2'h0;
  logic [1:0] ix = 2'h0;
  logic [1:0] brk = 2'h0;
  logic [1:0] ea, ean, eb, ebn, ei, ein;
  logic [1:0][31:0] co;
  logic [1:0][31:0] vo;
  logic [1:0][1:0] so;
  logic st;
  logic [2:0] c;
  logic [31:0] ex;
  int err_count = 0;
  int checks_done = 0;

  always #5 mclk_in = ~mclk_in;

  qec_top #(.CNT_W(32), .STEP_CYC(20)) u_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdq),
    .enc_a_in(ea), .enc_a_n_in(ean), .enc_b_in(eb), .enc_b_n_in(ebn), .enc_i_in(ei), .enc_i_n_in(ein),
    .count_out(co), .velocity_out(vo), .status_out(so), .step_out(st)
  );

  for (genvar g = 0; g < 2; g++)
  begin : g_enc
    qec_enc_model u_enc (
      .clk_in(mclk_in), .fwd_in(fw[g]), .rev_in(rv[g]), .both_in(bo[g]), .idx_in(ix[g]), .brk_in(brk[g]),
      .a_out(ea[g]), .an_out(ean[g]), .b_out(eb[g]), .bn_out(ebn[g]), .i_out(ei[g]), .in_out(ein[g])
    );
  end

  task automatic close_out;
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    ra <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    chk(rdq, e);
  endtask

  // Spacing covers the four-edge input latency
  task automatic mv(input int e, input int k, input int n);
    repeat (n)
    begin
      @(posedge mclk_in);
      fw[e] <= (k == 0);
      rv[e] <= (k == 1);
      bo[e] <= (k == 2);
      @(posedge mclk_in);
      fw <= 2'h0;
      rv <= 2'h0;
      bo <= 2'h0;
      repeat (5) @(posedge mclk_in);
    end
  endtask

  task automatic ip;
    @(posedge mclk_in);
    ix[0] <= 1'b1;
    repeat (6) @(posedge mclk_in);
    ix[0] <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic ws;
    int n;
    n = 0;
    @(posedge mclk_in);
    #1;
    while (st !== 1'b1 && n < 100)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (n >= 100)
    begin
      err_count++;
      $display("BAD %0t no step pulse", $time);
    end
  endtask

  initial
  begin
    #200000;
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rdc(8'h00, 32'h2);
    rdc(8'h04, 32'h2);
    rdc(8'h08, 32'hfff);
    rdc(8'h10, 32'h0);
    rdc(8'h18, 32'h0);
    rdc(8'h30, 32'h14);
    wrr(8'h40, 32'h1234);
    rdc(8'h40, 32'h0);
    wrr(8'h18, 32'h7);
    rdc(8'h18, 32'h0);
    wrr(8'h08, 32'h5);
    wrr(8'h00, 32'ha);
    mv(0, 0, 3);
    rdc(8'h18, 32'h3);
    mv(0, 1, 4);
    rdc(8'h18, 32'h5);
    mv(0, 0, 1);
    rdc(8'h18, 32'h0);
    mv(0, 2, 1);
    rdc(8'h18, 32'h0);
    wrr(8'h00, 32'he);
    mv(0, 0, 1);
    rdc(8'h18, 32'h5);
    mv(0, 1, 1);
    rdc(8'h18, 32'h0);
    // Maximum for 64 line pairs counted on all edges, then four forward edges in each counting mode
    wrr(8'h08, 32'hff);
    ex = 32'h0;
    for (int m = 0; m < 4; m++)
    begin
      wrr(8'h00, 32'h8 | m);
      mv(0, 0, 4);
      ex = ex + ((m == 3) ? 0 : (1 << m));
      rdc(8'h18, ex);
    end
    c = {ea[0], eb[0], 1'b1};
    wrr(8'h00, 32'h3a | (c << 6));
    ip();
    rdc(8'h18, 32'h0);
    mv(0, 0, 2);
    c = {ea[0], eb[0], 1'b1};
    wrr(8'h00, 32'h3a | ((c ^ 3'h4) << 6));
    ip();
    rdc(8'h18, 32'h2);
    wrr(8'h00, 32'h1a | (c << 6));
    ip();
    rdc(8'h18, 32'h2);
    wrr(8'h00, 32'h2a | (c << 6));
    ip();
    rdc(8'h18, 32'h2);
    wrr(8'h00, 32'h1a);
    ws();
    @(posedge mclk_in);
    ix[0] <= 1'b1;
    repeat (8) @(posedge mclk_in);
    ix[0] <= 1'b0;
    ws();
    chk({31'h0, so[0][1]}, 32'h1);
    chk(co[0], 32'h2);
    ws();
    chk({31'h0, so[0][1]}, 32'h0);
    wrr(8'h10, 32'h1);
    ws();
    mv(0, 0, 2);
    ws();
    chk(vo[0], 32'h2);
    chk({31'h0, so[0][0]}, 32'h1);
    mv(0, 1, 1);
    ws();
    chk(vo[0], 32'hffff_ffff);
    chk({31'h0, so[0][0]}, 32'h0);
    rdc(8'h20, 32'hffff_ffff);
    rdc(8'h28, 32'h0);
    // Zero maximum forces a known start for the second counter
    wrr(8'h0c, 32'h0);
    wrr(8'h04, 32'h202);
    mv(1, 0, 1);
    wrr(8'h0c, 32'hff);
    mv(1, 0, 3);
    rdc(8'h1c, 32'h3);
    rdc(8'h18, 32'h3);
    mv(0, 0, 2);
    rdc(8'h1c, 32'h3);
    ws();
    chk(co[1], 32'h3);
    // Equal true and complement must freeze the level until the pair is valid again
    @(posedge mclk_in);
    brk <= 2'h1;
    mv(0, 0, 1);
    rdc(8'h18, 32'h5);
    @(posedge mclk_in);
    brk <= 2'h0;
    repeat (6) @(posedge mclk_in);
    rdc(8'h18, 32'h6);
    close_out();
  end
endmodule
